//--- bench/testbench.sv
// Self-checking bench of the monitor: registers over the serial port,
// rate, alarm, standby and one-shot. Converter is a simple stand-in.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PCYC = 64;
  localparam logic [6:0] DEV = 7'h4D;
  logic        clock, reset_n, scl, sda_m, oe, standby_n, done;
  logic        start, abort, alarm_n, ack;
  logic [1:0]  sel_a, sel_b;
  logic [7:0]  loc, rem, d;
  int          n_mismatch, checked, n_start, n_abort, busy_cnt, s;
  wire         sda = sda_m & ~oe;
  logic [15:0] rst_tab [7] = '{16'h0300, 16'h0402, 16'h057F, 16'h06C9,
                               16'h077F, 16'h08C9, 16'h1100};
  logic [31:0] wr_tab [8] = '{32'h09FF_03C0, 32'h0A07_0407, 32'h0B5A_055A,
    32'h0C81_0681, 32'h0D33_0733, 32'h0EF0_08F0, 32'h11FC_11FC,
    32'h0900_0300};
  logic [2:0]  rc [3] = '{3'h0, 3'h3, 3'h7};

  tmsr_top #(.PERIOD_CYC(PCYC)) tmsr_top_i (.clock(clock),
    .reset_n(reset_n), .serial_clock_line(scl), .serial_data_line_in(sda),
    .serial_data_line_out(), .serial_data_line_oe(oe),
    .addr_select_first(sel_a), .addr_select_second(sel_b),
    .standby_pin_n(standby_n), .adc_done(done), .adc_local(loc),
    .adc_remote(rem), .adc_start(start), .adc_abort(abort),
    .alarm_n(alarm_n));
  tmsr_master tmsr_master_i (.clock(clock), .sda_in(sda), .scl(scl),
    .sda_o(sda_m));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Converter stand-in answers 40 clocks after each start
  always @(posedge clock) begin
    n_start <= n_start + int'(start);
    n_abort <= n_abort + int'(abort);
    busy_cnt <= (start === 1'b1) ? 40 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
    done <= (busy_cnt == 1);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic head(input logic rw);
    tmsr_master_i.start();
    tmsr_master_i.send({DEV, rw}, ack);
    chk({7'h00, ack}, 8'h01);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    head(1'b0);
    tmsr_master_i.send(p, ack);
    chk({7'h00, ack}, 8'h01);
    tmsr_master_i.send(v, ack);
    chk({7'h00, ack}, 8'h01);
    tmsr_master_i.stop();
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    head(1'b0);
    tmsr_master_i.send(p, ack);
    chk({7'h00, ack}, 8'h01);
    tmsr_master_i.stop();
    head(1'b1);
    tmsr_master_i.recv(d);
    tmsr_master_i.stop();
    chk(d, exp);
  endtask

  // A bound that runs out counts as a mismatch and ends the run
  task automatic expired(input logic late);
    if (late) begin
      n_mismatch++;
      $display("mismatch at %0t: wait ran out", $time);
      end_sim();
    end
  endtask

  task automatic wait_done;
    for (int i = 0; i < 5000 && done !== 1'b1; i++) @(posedge clock);
    expired(done !== 1'b1);
    repeat (4) @(posedge clock);
  endtask

  task automatic end_sim;
    $display("counts: %0d mismatch, %0d checked", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clock);
    expired(1'b1);
  end

  initial begin
    {reset_n, standby_n, done, sel_a, sel_b} = {3'h2, 2'h2, 2'h1};
    {loc, rem} = 16'h8012;
    {n_mismatch, checked, n_start, n_abort, busy_cnt} = '0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (10) @(posedge clock);
    sel_a <= 2'h0;
    sel_b <= 2'h0;
    head(1'b1);
    tmsr_master_i.recv(d);
    tmsr_master_i.stop();
    chk(d, 8'h80);
    tmsr_master_i.low_cyc = 20;
    tmsr_master_i.start();
    tmsr_master_i.send({7'h18, 1'b0}, ack);
    tmsr_master_i.stop();
    chk({7'h00, ack}, 8'h00);
    foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
    tmsr_master_i.low_cyc = 8;
    $display("test done: address and reset values");
    foreach (wr_tab[i]) begin
      wr(wr_tab[i][31:24], wr_tab[i][23:16]);
      rd(wr_tab[i][15:8], wr_tab[i][7:0]);
    end
    foreach (rc[c]) begin
      wr(8'h0A, {5'h00, rc[c]});
      s = n_start;
      for (int i = 0; i < 20000 && n_start == s; i++) @(posedge clock);
      expired(n_start == s);
      s = n_start;
      repeat (2 * (PCYC << (7 - rc[c])) - 8) @(posedge clock);
      chk(8'(n_start - s), 8'h01);
    end
    $display("test done: writes and rate");
    loc <= 8'h32;
    wr(8'h0B, 8'h32);
    wait_done();
    rd(8'h01, 8'h0E);
    rd(8'h00, 8'h32);
    chk({7'h00, alarm_n}, 8'h01);
    wr(8'h0B, 8'h31);
    wait_done();
    chk({7'h00, alarm_n}, 8'h00);
    wr(8'h09, 8'h80);
    wait_done();
    chk({7'h00, alarm_n}, 8'h01);
    $display("test done: offset and alarm");
    wr(8'h09, 8'h40);
    s = n_start;
    repeat (1000) @(posedge clock);
    chk(8'(n_start - s), 8'h00);
    wr(8'h0F, 8'hAA);
    repeat (100) @(posedge clock);
    chk(8'(n_start - s), 8'h01);
    rd(8'h03, 8'h40);
    standby_n <= 1'b0;
    wr(8'h0F, 8'h55);
    wr(8'h09, 8'h00);
    chk(8'(n_start - s), 8'h01);
    standby_n <= 1'b1;
    for (int i = 0; i < 1000 && n_start == s + 1; i++) @(posedge clock);
    expired(n_start == s + 1);
    s = n_abort;
    rem <= 8'h70;
    standby_n <= 1'b0;
    repeat (60) @(posedge clock);
    chk(8'(n_abort - s), 8'h01);
    rd(8'h01, 8'h0E);
    $display("test done: standby and one-shot");
    wr(8'h0B, 8'h10);
    head(1'b0);
    tmsr_master_i.send(8'h05, ack);
    tmsr_master_i.send(8'h20, ack);
    tmsr_master_i.stop();
    chk({7'h00, ack}, 8'h01);
    rd(8'h05, 8'h10);
    $display("test done: pointer only writes");
    end_sim();
  end
endmodule

//--- bench/tmsr_master.sv
// Behavioural bus master for the monitor's two-wire serial port.
// Assumes a pull-up on the data line: a released line reads high.
module tmsr_master (
  input  wire logic clock,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clocks per bus clock phase; raise it to act as a slow master
  int low_cyc = 8;

  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end

  // Data moves mid-low, is sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    repeat (low_cyc / 2) @(posedge clock);
    sda_o <= b;
    repeat (low_cyc / 2) @(posedge clock);
    scl <= 1'b1;
    repeat (low_cyc) @(posedge clock);
    r = sda_in;
    scl <= 1'b0;
  endtask

  task automatic start;
    repeat (4) @(posedge clock);
    sda_o <= 1'b1;
    repeat (4) @(posedge clock);
    scl <= 1'b1;
    repeat (low_cyc) @(posedge clock);
    sda_o <= 1'b0;
    repeat (low_cyc) @(posedge clock);
    scl <= 1'b0;
  endtask

  task automatic stop;
    repeat (4) @(posedge clock);
    sda_o <= 1'b0;
    repeat (4) @(posedge clock);
    scl <= 1'b1;
    repeat (4) @(posedge clock);
    sda_o <= 1'b1;
    repeat (low_cyc) @(posedge clock);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // A read always ends with a no-acknowledge
  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask
endmodule

//--- bench/tmsr_sva.sv
// Port checker of the monitor's serial slave and conversion control.
// Assumes the bus clock stays low and high at least four clocks a bit.
module tmsr_sva #(
  parameter int unsigned PERIOD_CYC = tmsr_pkg::FAST_PERIOD_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic standby_pin_n,
  input wire logic adc_start,
  input wire logic adc_abort
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Six samples cover the pin synchroniser and the start register
  sequence s_pin_low;
    !standby_pin_n [*6];
  endsequence
  sequence s_ack_high;
    serial_data_line_oe && serial_clock_line;
  endsequence

  a_open_drain: assert property (serial_data_line_out == 1'b0)
    else $error("data line driven high");
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("start pulse too long");
  a_abort_pulse: assert property (adc_abort |=> !adc_abort)
    else $error("abort pulse too long");
  a_pin_inhibit: assert property (s_pin_low |-> !adc_start)
    else $error("start while standby pin low");
  a_start_abort: assert property (!(adc_start && adc_abort))
    else $error("start and abort together");
  a_oe_scl_low: assert property (
    $changed(serial_data_line_oe) |-> !serial_clock_line)
    else $error("data moved while clock high");
  a_ack_stable: assert property (
    s_ack_high |=> serial_data_line_oe || !serial_clock_line)
    else $error("data released while clock high");
  a_oe_stands: assert property (
    $rose(serial_data_line_oe) |-> serial_data_line_oe [*6])
    else $error("driven bit too short");
  a_quiet_reset: assert property (
    $rose(reset_n) |-> !serial_data_line_oe && !adc_start)
    else $error("activity right after reset");
endmodule

bind tmsr_top tmsr_sva #(.PERIOD_CYC(PERIOD_CYC)) tmsr_sva_i (
  .clock(clock), .reset_n(reset_n), .serial_clock_line(serial_clock_line),
  .serial_data_line_out(serial_data_line_out),
  .serial_data_line_oe(serial_data_line_oe), .standby_pin_n(standby_pin_n),
  .adc_start(adc_start), .adc_abort(adc_abort));

//--- verilog/tmsr_pkg.sv
// Package of the temperature monitor register and serial slave logic.
// Assumes a single 125 MHz clock; all users refer to names with tmsr_pkg::.
package tmsr_pkg;
  // Clock and the fastest conversion period
  localparam int unsigned CLOCK_HZ        = 125_000_000;
  localparam int unsigned FAST_PERIOD_MS  = 125;
  localparam int unsigned FAST_PERIOD_CYC = CLOCK_HZ / 1000 * FAST_PERIOD_MS;
  localparam int unsigned PERIOD_W        = 24;

  // Read locations of the pointer
  localparam logic [7:0] RD_LOCAL      = 8'h00;
  localparam logic [7:0] RD_REMOTE     = 8'h01;
  localparam logic [7:0] RD_STATUS     = 8'h02;
  localparam logic [7:0] RD_CONFIG     = 8'h03;
  localparam logic [7:0] RD_RATE       = 8'h04;
  localparam logic [7:0] RD_LOC_HIGH   = 8'h05;
  localparam logic [7:0] RD_LOC_LOW    = 8'h06;
  localparam logic [7:0] RD_REM_HIGH   = 8'h07;
  localparam logic [7:0] RD_REM_LOW    = 8'h08;
  localparam logic [7:0] RW_OFFSET     = 8'h11;
  // Write locations of the pointer
  localparam logic [7:0] WR_CONFIG     = 8'h09;
  localparam logic [7:0] WR_RATE       = 8'h0A;
  localparam logic [7:0] WR_LOC_HIGH   = 8'h0B;
  localparam logic [7:0] WR_LOC_LOW    = 8'h0C;
  localparam logic [7:0] WR_REM_HIGH   = 8'h0D;
  localparam logic [7:0] WR_REM_LOW    = 8'h0E;
  localparam logic [7:0] WR_ONE_SHOT   = 8'h0F;

  // Configuration fields
  localparam int unsigned CFG_ALARM_MASK_BIT = 7;
  localparam int unsigned CFG_STANDBY_BIT    = 6;
  localparam logic [7:0]  CFG_USED_MASK      = 8'hC0;
  localparam int unsigned RATE_CODE_W        = 3;
  localparam logic [2:0]  RATE_FASTEST       = 3'h7;

  // Reset values
  localparam logic [7:0] RST_CONFIG   = 8'h00;
  localparam logic [7:0] RST_RATE     = 8'h02;
  localparam logic [7:0] RST_HIGH     = 8'h7F;
  localparam logic [7:0] RST_LOW      = 8'hC9;
  localparam logic [7:0] RST_VALUE    = 8'h80;
  localparam logic [7:0] RST_OFFSET   = 8'h00;
  localparam logic [7:0] RST_POINTER  = 8'h00;

  // Status bit positions
  localparam int unsigned ST_BUSY     = 7;
  localparam int unsigned ST_LOC_HIGH = 6;
  localparam int unsigned ST_LOC_LOW  = 5;
  localparam int unsigned ST_REM_HIGH = 4;
  localparam int unsigned ST_REM_LOW  = 3;

  // Three-level select pin codes
  localparam logic [1:0] SEL_LOW   = 2'h0;
  localparam logic [1:0] SEL_FLOAT = 2'h1;
  localparam logic [1:0] SEL_HIGH  = 2'h2;
  localparam logic [3:0] PREFIX_LOW   = 4'h3;
  localparam logic [3:0] PREFIX_FLOAT = 4'h5;
  localparam logic [3:0] PREFIX_HIGH  = 4'h9;
  localparam logic [2:0] BASE_LOW     = 3'h0;
  localparam logic [2:0] BASE_FLOAT   = 3'h1;
  localparam logic [2:0] BASE_HIGH    = 3'h4;

  // Serial engine
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] STRAP_DELAY   = 2'h2;

  typedef enum logic [2:0] {
    TMSR_IDLE  = 3'b000,
    TMSR_ADDR  = 3'b001,
    TMSR_AACK  = 3'b010,
    TMSR_WDATA = 3'b011,
    TMSR_WACK  = 3'b100,
    TMSR_RDATA = 3'b101,
    TMSR_RACK  = 3'b110,
    TMSR_WAIT  = 3'b111
  } tmsr_state_t;
endpackage

//--- verilog/tmsr_sched.sv
// Conversion scheduler: rate divider, one-shot and standby abort.
// Assumes the converter answers a start with one done pulse on this clock.
module tmsr_sched #(
  parameter int unsigned PERIOD_CYC = tmsr_pkg::FAST_PERIOD_CYC
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [2:0] rate_code,
  input  wire logic       standby_bit,
  input  wire logic       standby_pin_q,
  input  wire logic       one_shot_req,
  input  wire logic       adc_done,
  output logic            adc_start,
  output logic            adc_abort,
  output logic            busy,
  output logic            commit
);
  typedef struct packed {
    logic [tmsr_pkg::PERIOD_W-1:0] base_cnt;
    logic [7:0]                    mult_cnt;
    logic                          busy;
    logic                          single;
    logic                          start;
    logic                          abort;
    logic                          commit;
  } tmsr_sched_t;

  localparam logic [tmsr_pkg::PERIOD_W-1:0] BASE_LAST =
    tmsr_pkg::PERIOD_W'(PERIOD_CYC - 1);

  tmsr_sched_t cur;
  tmsr_sched_t next_cur;
  logic        running;
  logic        tick;
  logic [7:0]  divide;

  always_comb begin
    next_cur        = cur;
    next_cur.start  = 1'b0;
    next_cur.abort  = 1'b0;
    next_cur.commit = 1'b0;
    running = !standby_bit && standby_pin_q;
    divide  = 8'h01 << (tmsr_pkg::RATE_FASTEST - rate_code);
    tick    = cur.base_cnt == BASE_LAST;
    next_cur.base_cnt = tick ? '0 : cur.base_cnt + 1'b1;
    if (tick) begin
      next_cur.mult_cnt = (cur.mult_cnt >= divide - 8'h01) ?
                          8'h00 : cur.mult_cnt + 8'h01;
    end
    if (cur.busy && (!standby_pin_q || (standby_bit && !cur.single))) begin
      // Abort drops the result: values keep what they held
      next_cur.busy  = 1'b0;
      next_cur.abort = 1'b1;
    end else if (cur.busy && adc_done) begin
      next_cur.busy   = 1'b0;
      next_cur.commit = 1'b1;
    end else if (!cur.busy && running && tick &&
                 cur.mult_cnt >= divide - 8'h01) begin
      next_cur.busy   = 1'b1;
      next_cur.single = 1'b0;
      next_cur.start  = 1'b1;
    end else if (!cur.busy && one_shot_req && standby_bit &&
                 standby_pin_q) begin
      next_cur.busy   = 1'b1;
      next_cur.single = 1'b1;
      next_cur.start  = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign adc_start = cur.start;
  assign adc_abort = cur.abort;
  assign busy      = cur.busy;
  assign commit    = cur.commit;
endmodule

//--- verilog/tmsr_top.sv
// Serial slave, register file and limit comparison of a two-channel
// temperature monitor. Assumes an external open-drain pad resolves the data
// line from oe, and a converter on the same clock answering adc_start.
module tmsr_top #(
  parameter int unsigned PERIOD_CYC = tmsr_pkg::FAST_PERIOD_CYC
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       serial_clock_line,
  input  wire logic       serial_data_line_in,
  output logic            serial_data_line_out,
  output logic            serial_data_line_oe,
  input  wire logic [1:0] addr_select_first,
  input  wire logic [1:0] addr_select_second,
  input  wire logic       standby_pin_n,
  input  wire logic       adc_done,
  input  wire logic [7:0] adc_local,
  input  wire logic [7:0] adc_remote,
  output logic            adc_start,
  output logic            adc_abort,
  output logic            alarm_n
);
  typedef struct packed {
    logic [1:0]            scl_s;
    logic [1:0]            sda_s;
    logic [1:0]            standby_pin_n_s;
    logic [3:0]            sel_s;
    logic [3:0]            sel_q;
    logic                  scl_d;
    logic                  sda_d;
    logic [1:0]            strap_wait;
    logic                  strap_done;
    logic [6:0]            slave_addr;
    tmsr_pkg::tmsr_state_t state;
    logic [3:0]            cnt;
    logic [7:0]            shreg;
    logic [7:0]            tx;
    logic                  rw;
    logic                  second;
    logic                  sda_oe;
    logic [7:0]            pointer;
    logic [7:0]            configuration;
    logic [7:0]            conversion_rate;
    logic [7:0]            local_high;
    logic [7:0]            local_low;
    logic [7:0]            remote_high;
    logic [7:0]            remote_low;
    logic [7:0]            remote_offset;
    logic [7:0]            local_value;
    logic [7:0]            remote_value;
    logic                  one_shot;
    logic                  alarm;
  } tmsr_top_t;

  tmsr_top_t  cur;
  tmsr_top_t  next_cur;
  logic       busy;
  logic       commit;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic [3:0] trips;
  logic [7:0] rd_byte;

  function automatic logic [6:0] slave_address(input logic [1:0] first,
                                               input logic [1:0] second);
    logic [3:0] prefix;
    logic [2:0] base;
    prefix = tmsr_pkg::PREFIX_LOW;
    base   = tmsr_pkg::BASE_LOW;
    case (first)
      tmsr_pkg::SEL_FLOAT: begin
        prefix = tmsr_pkg::PREFIX_FLOAT;
        base   = tmsr_pkg::BASE_FLOAT;
      end
      tmsr_pkg::SEL_HIGH: begin
        prefix = tmsr_pkg::PREFIX_HIGH;
        base   = tmsr_pkg::BASE_HIGH;
      end
      default: begin
        prefix = tmsr_pkg::PREFIX_LOW;
        base   = tmsr_pkg::BASE_LOW;
      end
    endcase
    slave_address = {prefix, base + {1'b0, second}};
  endfunction

  // Signed compare: high trips on greater, low on less, equality never trips
  function automatic logic [1:0] limit_trip(input logic [7:0] value,
                                            input logic [7:0] high,
                                            input logic [7:0] low);
    limit_trip = {$signed(value) > $signed(high),
                  $signed(value) < $signed(low)};
  endfunction

  function automatic logic [7:0] reg_read(input tmsr_top_t s,
                                          input logic      is_busy,
                                          input logic [3:0] trip);
    case (s.pointer)
      tmsr_pkg::RD_LOCAL:    reg_read = s.local_value;
      tmsr_pkg::RD_REMOTE:   reg_read = s.remote_value;
      tmsr_pkg::RD_STATUS:   reg_read = {is_busy, trip, 3'h0};
      tmsr_pkg::RD_CONFIG:   reg_read = s.configuration
                                        & tmsr_pkg::CFG_USED_MASK;
      tmsr_pkg::RD_RATE:     reg_read = s.conversion_rate;
      tmsr_pkg::RD_LOC_HIGH: reg_read = s.local_high;
      tmsr_pkg::RD_LOC_LOW:  reg_read = s.local_low;
      tmsr_pkg::RD_REM_HIGH: reg_read = s.remote_high;
      tmsr_pkg::RD_REM_LOW:  reg_read = s.remote_low;
      tmsr_pkg::RW_OFFSET:   reg_read = s.remote_offset;
      default:               reg_read = 8'h00;
    endcase
  endfunction

  assign scl      = cur.scl_s[1];
  assign sda      = cur.sda_s[1];
  assign scl_rise = scl && !cur.scl_d;
  assign scl_fall = !scl && cur.scl_d;
  assign trips    = {limit_trip(cur.local_value, cur.local_high,
                                cur.local_low),
                     limit_trip(cur.remote_value, cur.remote_high,
                                cur.remote_low)};
  // Selected byte as a net, so its top bit can be picked for the line
  assign rd_byte  = reg_read(cur, busy, trips);

  always_comb begin
    next_cur          = cur;
    next_cur.one_shot = 1'b0;
    // Two-stage synchronisers for the bus, standby and select pins; converter inputs are used directly
    next_cur.scl_s  = {cur.scl_s[0], serial_clock_line};
    next_cur.sda_s  = {cur.sda_s[0], serial_data_line_in};
    next_cur.standby_pin_n_s = {cur.standby_pin_n_s[0], standby_pin_n};
    next_cur.sel_s  = {addr_select_first, addr_select_second};
    next_cur.sel_q  = cur.sel_s;
    next_cur.scl_d  = scl;
    next_cur.sda_d  = sda;
    // Strap is taken once, after the synchronisers have filled
    if (!cur.strap_done) begin
      if (cur.strap_wait == tmsr_pkg::STRAP_DELAY) begin
        next_cur.strap_done = 1'b1;
        next_cur.slave_addr = slave_address(cur.sel_q[3:2], cur.sel_q[1:0]);
      end else begin
        next_cur.strap_wait = cur.strap_wait + 2'h1;
      end
    end

    if (commit) begin
      next_cur.local_value  = adc_local;
      next_cur.remote_value = adc_remote + cur.remote_offset;
    end
    // Alarm masked by config bit 7
    next_cur.alarm = |trips &&
      !cur.configuration[tmsr_pkg::CFG_ALARM_MASK_BIT];

    if (scl && cur.scl_d && cur.sda_d && !sda && cur.strap_done) begin
      next_cur.state  = tmsr_pkg::TMSR_ADDR;
      next_cur.cnt    = 4'h0;
      next_cur.sda_oe = 1'b0;
    end else if (scl && cur.scl_d && !cur.sda_d && sda) begin
      next_cur.state  = tmsr_pkg::TMSR_IDLE;
      next_cur.sda_oe = 1'b0;
    end else if (scl_rise) begin
      // Sample on rising clock only, data stable while high
      if (cur.state == tmsr_pkg::TMSR_ADDR ||
          cur.state == tmsr_pkg::TMSR_WDATA) begin
        next_cur.shreg = {cur.shreg[6:0], sda};
        next_cur.cnt   = cur.cnt + 4'h1;
      end else if (cur.state == tmsr_pkg::TMSR_RACK) begin
        next_cur.rw = sda;
      end
    end else if (scl_fall) begin
      // All line changes happen after a falling clock
      case (cur.state)
        tmsr_pkg::TMSR_ADDR: begin
          if (cur.cnt == tmsr_pkg::BITS_PER_BYTE) begin
            if (cur.shreg[7:1] == cur.slave_addr) begin
              next_cur.sda_oe = 1'b1;
              next_cur.rw     = cur.shreg[0];
              next_cur.state  = tmsr_pkg::TMSR_AACK;
            end else begin
              next_cur.state = tmsr_pkg::TMSR_WAIT;
            end
          end
        end
        tmsr_pkg::TMSR_AACK: begin
          next_cur.cnt    = 4'h0;
          next_cur.second = 1'b0;
          if (cur.rw) begin
            next_cur.tx     = rd_byte;
            next_cur.sda_oe = !rd_byte[7];
            next_cur.state  = tmsr_pkg::TMSR_RDATA;
          end else begin
            next_cur.sda_oe = 1'b0;
            next_cur.state  = tmsr_pkg::TMSR_WDATA;
          end
        end
        tmsr_pkg::TMSR_WDATA: begin
          if (cur.cnt == tmsr_pkg::BITS_PER_BYTE) begin
            next_cur.state = tmsr_pkg::TMSR_WACK;
            if (!cur.second) begin
              next_cur.sda_oe  = 1'b1;
              next_cur.pointer = cur.shreg;
            end else begin
              next_cur.sda_oe = 1'b1;
              case (cur.pointer)
                tmsr_pkg::WR_CONFIG:   next_cur.configuration =
                  cur.shreg & tmsr_pkg::CFG_USED_MASK;
                tmsr_pkg::WR_RATE:     next_cur.conversion_rate = cur.shreg;
                tmsr_pkg::WR_LOC_HIGH: next_cur.local_high = cur.shreg;
                tmsr_pkg::WR_LOC_LOW:  next_cur.local_low = cur.shreg;
                tmsr_pkg::WR_REM_HIGH: next_cur.remote_high = cur.shreg;
                tmsr_pkg::WR_REM_LOW:  next_cur.remote_low = cur.shreg;
                tmsr_pkg::RW_OFFSET:   next_cur.remote_offset = cur.shreg;
                tmsr_pkg::WR_ONE_SHOT: next_cur.one_shot = 1'b1;
                default:               next_cur.one_shot = 1'b0;
              endcase
            end
          end
        end
        tmsr_pkg::TMSR_WACK: begin
          next_cur.sda_oe = 1'b0;
          next_cur.cnt    = 4'h0;
          // A third byte is not acknowledged and not stored
          next_cur.state  = cur.second ? tmsr_pkg::TMSR_WAIT
                                       : tmsr_pkg::TMSR_WDATA;
          next_cur.second = 1'b1;
        end
        tmsr_pkg::TMSR_RDATA: begin
          next_cur.cnt = cur.cnt + 4'h1;
          if (cur.cnt == tmsr_pkg::BITS_PER_BYTE - 4'h1) begin
            next_cur.sda_oe = 1'b0;
            next_cur.state  = tmsr_pkg::TMSR_RACK;
          end else begin
            next_cur.tx     = {cur.tx[6:0], 1'b0};
            next_cur.sda_oe = !cur.tx[6];
          end
        end
        tmsr_pkg::TMSR_RACK: begin
          // One byte per read, whatever the master answered
          next_cur.state = tmsr_pkg::TMSR_WAIT;
        end
        tmsr_pkg::TMSR_IDLE,
        tmsr_pkg::TMSR_WAIT: begin
          next_cur.sda_oe = 1'b0;
        end
        default: begin
          next_cur.state  = tmsr_pkg::TMSR_IDLE;
          next_cur.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur                 <= '0;
      cur.scl_s           <= 2'h3;
      cur.sda_s           <= 2'h3;
      cur.standby_pin_n_s          <= 2'h3;
      cur.scl_d           <= 1'b1;
      cur.sda_d           <= 1'b1;
      cur.state           <= tmsr_pkg::TMSR_IDLE;
      cur.pointer         <= tmsr_pkg::RST_POINTER;
      cur.configuration   <= tmsr_pkg::RST_CONFIG;
      cur.conversion_rate <= tmsr_pkg::RST_RATE;
      cur.local_high      <= tmsr_pkg::RST_HIGH;
      cur.local_low       <= tmsr_pkg::RST_LOW;
      cur.remote_high     <= tmsr_pkg::RST_HIGH;
      cur.remote_low      <= tmsr_pkg::RST_LOW;
      cur.remote_offset   <= tmsr_pkg::RST_OFFSET;
      cur.local_value     <= tmsr_pkg::RST_VALUE;
      cur.remote_value    <= tmsr_pkg::RST_VALUE;
    end else begin
      cur <= next_cur;
    end
  end

  tmsr_sched #(
    .PERIOD_CYC(PERIOD_CYC)
  ) u_sched (
    .clock         (clock),
    .reset_n       (reset_n),
    .rate_code     (cur.conversion_rate[tmsr_pkg::RATE_CODE_W-1:0]),
    .standby_bit   (cur.configuration[tmsr_pkg::CFG_STANDBY_BIT]),
    .standby_pin_q (cur.standby_pin_n_s[1]),
    .one_shot_req  (cur.one_shot),
    .adc_done      (adc_done),
    .adc_start     (adc_start),
    .adc_abort     (adc_abort),
    .busy          (busy),
    .commit        (commit)
  );

  // Line is only ever pulled low; oe high means pulling
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe  = cur.sda_oe;
  assign alarm_n              = !cur.alarm;
endmodule
